//--- csd_defs.svh
// Purpose: Constants of the chip-select decoder: register map, fields, resets, timing.
// Assumes: 200 MHz processor clock, 32-bit AHB-Lite register port.
// Notes: Offsets, configuration field positions, reset values and timing counts of the block.
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH
// Register byte offsets and word indices.
`define CSD_OFS_CFG0 8'h00
`define CSD_OFS_RNG1 8'h14
`define CSD_OFS_STATUS 8'h24
`define CSD_IDX_RNG1 6'h05
`define CSD_IDX_STATUS 6'h09
// Bus configuration fields.
`define CSD_CFG_WAIT_MSB 3
`define CSD_CFG_STROBE_DLY 4
`define CSD_CFG_TURN_DLY 5
`define CSD_CFG_MUX 6
`define CSD_CFG_WIDE 7
`define CSD_CFG_EARLY_WR 8
`define CSD_CFG_ALE_LONG 9
`define CSD_CFG_ACTIVE 10
// Reset values.
`define CSD_CFG0_RST 16'h0480
`define CSD_SWAP_RST 2'h1
// Timing, and the largest range size code.
`define CSD_CLK_MHZ 200
`define CSD_WAIT_STEP_NS 50
`define CSD_STROBE_DLY_NS 25
`define CSD_TURN_DLY_NS 25
`define CSD_ALE_NS 25
`define CSD_NS2CYC(ns) (((ns) * `CSD_CLK_MHZ + 999) / 1000)
`define CSD_WAIT_STEP_CYC `CSD_NS2CYC(`CSD_WAIT_STEP_NS)
`define CSD_STROBE_DLY_CYC `CSD_NS2CYC(`CSD_STROBE_DLY_NS)
`define CSD_TURN_DLY_CYC `CSD_NS2CYC(`CSD_TURN_DLY_NS)
`define CSD_ALE_CYC `CSD_NS2CYC(`CSD_ALE_NS)
`define CSD_SIZE_MAX 4'hb
`endif

//--- csd_pkg.sv
// Purpose: Types shared by the chip-select decoder and its users.
// Assumes: Constants come from csd_defs.svh.
// Notes: Request and pin groups travel as packed structs.
package csd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_ALE = 6'h04,
    ST_DLY = 6'h08,
    ST_STRB = 6'h10,
    ST_TURN = 6'h20
  } csd_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } csd_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] rdata;
  } csd_resp_t;

  typedef struct packed {
    logic [4:0] cs_n;
    logic flash_sel_n;
    logic sram_sel_n;
    logic [23:0] addr;
    logic [15:0] dout;
    logic doe;
    logic ale;
    logic rd_n;
    logic wr_n;
  } csd_pins_t;
endpackage : csd_pkg

//--- csd_decoder.sv
// Purpose: Chip-select decoder and external bus cycle timer with AHB-Lite registers.
// Assumes: One 200 MHz clock; req_i comes from logic on that clock; din_i is a pin.
// Notes: Register map and field positions live in csd_defs.svh.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`include "csd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module csd_decoder
  import csd_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // External access request and answer.
  input wire csd_pkg::csd_req_t req_i,
  output csd_pkg::csd_resp_t resp_o,
  // External bus pins.
  input wire logic [15:0] din_i,
  output csd_pkg::csd_pins_t pins_o
);
  import csd_pkg::*;

  // Bus cycle outline, one external access:
  //   idle   - a request is taken and its region, configuration and data are latched;
  //   start  - the region's select drops, the address goes out and the latch strobe rises;
  //   latch  - the latch strobe stands for five cycles, or ten with the long-strobe bit;
  //   delay  - five cycles of strobe delay unless the configuration removes them;
  //   strobe - read or write strobe low for the base step plus every wait state;
  //   turn   - all strobes and selects high for the turnaround, then done or the high byte.
  // A word on an 8-bit region runs the outline from start to turn twice, low byte first at the even
  // address and high byte second at the odd one, both on the lower eight data lines.
  //
  // Register words on the slave port, one 16-bit value in bits 15:0 of each word:
  //   0x00 to 0x10 - bus configuration of regions zero to four;
  //   0x14 to 0x20 - address range of regions one to four;
  //   0x24         - status, read only: swap code, asserted selects and the busy flag.
  // Writes to any other word are dropped and reads of it return zero.
  //
  // Hazards worth knowing before touching this block:
  //   the read data lags the pins by the two synchroniser stages, so the strobe must be
  //   at least three cycles long; the shortest legal strobe is ten;
  //   the register file is written in the data phase, so a read in the very next address
  //   phase still sees the old word, because the slave never inserts a wait state;
  //   a new configuration written while a cycle runs applies from the next request only,
  //   because the region's word is copied into the cycle at the moment of taking it;
  //   range codes above eleven match nothing, so such a region falls to the default select.
  //
  // The board steering of selects zero and one onto flash and SRAM follows the swap code;
  // it is computed from the next select value so that both lines switch on the same edge.
  typedef struct packed {
    // Sequencer state and its down counter.
    csd_state_t st;
    logic [7:0] cnt;
    // Register file: five configurations, four ranges, the swap code.
    logic [4:0][15:0] cfg;
    logic [4:1][15:0] rng;
    logic [1:0] swap;
    // Slave port pipeline between address and data phase.
    logic hpend;
    logic hwr;
    logic [5:0] hidx;
    logic [31:0] hrdata;
    logic hready;
    // The access being served, copied when it is taken.
    logic [2:0] reg_sel;
    logic [15:0] rcfg;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic word;
    logic hi;
    logic [15:0] rdata;
    // Two-stage synchroniser on the data pins.
    logic [15:0] din_m1;
    logic [15:0] din_m2;
    csd_resp_t resp;
    csd_pins_t pins;
  } csd_regs_t;

  csd_regs_t s_ff;
  csd_regs_t nxt_s;

  // Range hit: compare only the start bits above the block size.
  // The size code shifts the mask left, so a 4 KByte block compares all twelve bits
  // and an 8 MByte block only the top one; codes above eleven never hit.
  function automatic logic range_hit(input logic [15:0] rng, input logic [23:0] a);
    logic [11:0] mask;
    mask = 12'hfff << rng[3:0];
    range_hit = (rng[3:0] <= `CSD_SIZE_MAX)
      && (((a[23:12] ^ rng[15:4]) & mask) == 12'h000);
  endfunction : range_hit

  // Region lookup; lowest numbered hit wins, no hit falls to the default.
  // Counting down lets the lowest index overwrite the others, so overlapping ranges
  // resolve without a priority encoder of their own.
  function automatic logic [2:0] region_of(input csd_regs_t s, input logic [23:0] a);
    logic [2:0] r;
    r = 3'd0;
    for (int i = 4; i >= 1; i--)
    begin
      if (s.cfg[i][`CSD_CFG_ACTIVE] && range_hit(s.rng[i], a))
      begin
        r = 3'(i);
      end
    end
    region_of = r;
  endfunction : region_of

  // Register read mux; unmapped words read as zero.
  // Only address bits 7:2 are decoded, so the map repeats every 256 bytes.
  // The status word shows the select lines as asserted ones, not as pin levels.
  function automatic logic [31:0] reg_read(input csd_regs_t s, input logic [5:0] idx);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx < `CSD_IDX_RNG1)
    begin
      d = {16'h0000, s.cfg[idx[2:0]]};
    end
    else if (idx < `CSD_IDX_STATUS)
    begin
      d = {16'h0000, s.rng[3'(idx - `CSD_IDX_RNG1) + 3'd1]};
    end
    else if (idx == `CSD_IDX_STATUS)
    begin
      d = {23'h000000, s.resp.busy, 1'b0, ~s.pins.cs_n, s.swap};
    end
    reg_read = d;
  endfunction : reg_read

  // Strobe length: base step plus inverted wait field, each 50 ns.
  // The field counts down from fifteen, so its inverse is the number of wait states;
  // the result is one less than the strobe length because the counter ends at zero.
  function automatic logic [7:0] strobe_len(input logic [15:0] c);
    logic [7:0] ws;
    ws = {4'h0, ~c[`CSD_CFG_WAIT_MSB:0]};
    strobe_len = 8'((ws + 8'd1) * 8'(`CSD_WAIT_STEP_CYC) - 8'd1);
  endfunction : strobe_len

  // Next-state logic for the register file and the bus cycle sequencer.
  // Every field starts from its registered value, so a path that does not assign it
  // simply holds it; only the done pulse, the slave ready, the slave port pipeline, the synchroniser and the steering outputs are forced each cycle.
  always_comb
  begin
    logic [2:0] sel;
    logic [23:0] a;
    logic [4:0] csn;
    sel = 3'd0;
    a = 24'h000000;
    csn = 5'h1f;
    nxt_s = s_ff;
    // The pins come from another domain and pass two stages before use.
    nxt_s.din_m1 = din_i;
    nxt_s.din_m2 = s_ff.din_m1;
    nxt_s.resp.done = 1'b0;
    nxt_s.hready = 1'b1;

    // AHB data phase: writes land one cycle after the address phase.
    if (s_ff.hpend && s_ff.hwr)
    begin
      if (s_ff.hidx < `CSD_IDX_RNG1)
      begin
        nxt_s.cfg[s_ff.hidx[2:0]] = hwdata_i[15:0];
      end
      else if (s_ff.hidx < `CSD_IDX_STATUS)
      begin
        nxt_s.rng[3'(s_ff.hidx - `CSD_IDX_RNG1) + 3'd1] = hwdata_i[15:0];
      end
    end
    // AHB address phase: read data is prepared here so no wait states occur.
    nxt_s.hpend = hsel_i && htrans_i[1] && hready_i;
    nxt_s.hwr = hwrite_i;
    nxt_s.hidx = haddr_i[7:2];
    nxt_s.hrdata = reg_read(s_ff, haddr_i[7:2]);

    unique case (s_ff.st)
      // Take a request only while idle; one arriving while busy is ignored.
      ST_IDLE:
      begin
        if (req_i.valid)
        begin
          sel = region_of(s_ff, req_i.addr);
          nxt_s.reg_sel = sel;
          nxt_s.rcfg = s_ff.cfg[sel];
          nxt_s.addr = req_i.addr;
          nxt_s.wdata = req_i.wdata;
          nxt_s.wr = req_i.write;
          nxt_s.word = req_i.word;
          nxt_s.hi = 1'b0;
          nxt_s.rdata = 16'h0000;
          nxt_s.resp.busy = 1'b1;
          nxt_s.st = ST_START;
        end
      end

      // Drive select, address and latch strobe for one access.
      ST_START:
      begin
        // Second byte of an 8-bit word goes to the odd address.
        a = {s_ff.addr[23:1], s_ff.addr[0] | s_ff.hi};
        csn = 5'h1f;
        csn[s_ff.reg_sel] = 1'b0;
        nxt_s.pins.cs_n = csn;
        nxt_s.pins.addr = a;
        nxt_s.pins.ale = 1'b1;
        nxt_s.pins.doe = s_ff.rcfg[`CSD_CFG_MUX];
        nxt_s.pins.dout = a[15:0];
        nxt_s.cnt = s_ff.rcfg[`CSD_CFG_ALE_LONG] ?
          8'(2 * `CSD_ALE_CYC - 1) : 8'(`CSD_ALE_CYC - 1);
        nxt_s.st = ST_ALE;
      end

      // Hold the latch strobe, then put write data out and pick delay or strobe.
      ST_ALE:
      begin
        nxt_s.cnt = s_ff.cnt - 8'd1;
        if (s_ff.cnt == 8'd0)
        begin
          nxt_s.pins.ale = 1'b0;
          nxt_s.pins.doe = s_ff.wr;
          if (!s_ff.rcfg[`CSD_CFG_WIDE])
          begin
            // Narrow regions carry each byte on D0-D7.
            nxt_s.pins.dout = {8'h00, s_ff.hi ? s_ff.wdata[15:8] : s_ff.wdata[7:0]};
          end
          else
          begin
            nxt_s.pins.dout = s_ff.wdata;
          end
          // Early write starts the write strobe without the delay.
          if (s_ff.rcfg[`CSD_CFG_STROBE_DLY] || (s_ff.wr && s_ff.rcfg[`CSD_CFG_EARLY_WR]))
          begin
            nxt_s.pins.rd_n = s_ff.wr;
            nxt_s.pins.wr_n = !s_ff.wr;
            nxt_s.cnt = strobe_len(s_ff.rcfg);
            nxt_s.st = ST_STRB;
          end
          else
          begin
            nxt_s.cnt = 8'(`CSD_STROBE_DLY_CYC - 1);
            nxt_s.st = ST_DLY;
          end
        end
      end

      // Strobe delay for regions that keep it.
      ST_DLY:
      begin
        nxt_s.cnt = s_ff.cnt - 8'd1;
        if (s_ff.cnt == 8'd0)
        begin
          nxt_s.pins.rd_n = s_ff.wr;
          nxt_s.pins.wr_n = !s_ff.wr;
          nxt_s.cnt = strobe_len(s_ff.rcfg);
          nxt_s.st = ST_STRB;
        end
      end

      // Strobe low for the wait states; the last cycle samples data and ends the select.
      ST_STRB:
      begin
        nxt_s.cnt = s_ff.cnt - 8'd1;
        if (s_ff.cnt == 8'd0)
        begin
          // Read data sampled here lags the pins by two cycles of synchroniser.
          if (!s_ff.wr)
          begin
            if (s_ff.rcfg[`CSD_CFG_WIDE])
            begin
              nxt_s.rdata = s_ff.din_m2;
            end
            else if (s_ff.hi)
            begin
              nxt_s.rdata[15:8] = s_ff.din_m2[7:0];
            end
            else
            begin
              nxt_s.rdata[7:0] = s_ff.din_m2[7:0];
            end
          end
          // Swap register: select two with A8 low, data bits D0 and D1.
          if (s_ff.wr && s_ff.reg_sel == 3'd2 && !s_ff.pins.addr[8])
          begin
            nxt_s.swap = s_ff.pins.dout[1:0];
          end
          nxt_s.pins.rd_n = 1'b1;
          nxt_s.pins.wr_n = 1'b1;
          nxt_s.pins.cs_n = 5'h1f;
          nxt_s.pins.doe = 1'b0;
          nxt_s.cnt = s_ff.rcfg[`CSD_CFG_TURN_DLY] ? 8'd0 : 8'(`CSD_TURN_DLY_CYC - 1);
          nxt_s.st = ST_TURN;
        end
      end

      // Turnaround with all lines high; a narrow word starts its high byte from here.
      ST_TURN:
      begin
        nxt_s.cnt = s_ff.cnt - 8'd1;
        if (s_ff.cnt == 8'd0)
        begin
          if (!s_ff.rcfg[`CSD_CFG_WIDE] && s_ff.word && !s_ff.hi)
          begin
            nxt_s.hi = 1'b1;
            nxt_s.st = ST_START;
          end
          else
          begin
            nxt_s.resp.done = 1'b1;
            nxt_s.resp.busy = 1'b0;
            nxt_s.resp.rdata = s_ff.rdata;
            nxt_s.st = ST_IDLE;
          end
        end
      end

      // An illegal state code falls back to idle.
      default:
      begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // Board steering of selects zero and one onto flash and SRAM.
    csn = nxt_s.pins.cs_n;
    nxt_s.pins.flash_sel_n = !((!csn[0] && !nxt_s.swap[1]) || (!csn[1] && !nxt_s.swap[0]));
    nxt_s.pins.sram_sel_n = !((!csn[0] && nxt_s.swap[1]) || (!csn[1] && nxt_s.swap[0]));
  end

  // State register; reset leaves only the default region configured.
  // Reset loads constants only; the steering outputs stay high because no select
  // is asserted until the first request is taken.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.cfg[0] <= `CSD_CFG0_RST;
      s_ff.swap <= `CSD_SWAP_RST;
      s_ff.hready <= 1'b1;
      s_ff.pins.cs_n <= 5'h1f;
      s_ff.pins.flash_sel_n <= 1'b1;
      s_ff.pins.sram_sel_n <= 1'b1;
      s_ff.pins.rd_n <= 1'b1;
      s_ff.pins.wr_n <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Outputs come straight from the state register, except hresp_o, which is tied low.
  // The slave never stretches a transfer and always answers OKAY.
  assign hrdata_o = s_ff.hrdata;
  assign hreadyout_o = s_ff.hready;
  assign hresp_o = 1'b0;
  assign resp_o = s_ff.resp;
  assign pins_o = s_ff.pins;
endmodule : csd_decoder
`default_nettype wire

//--- csd_decoder_sva.sv
// Purpose: Port checks for the chip-select decoder.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module csd_sva_chk
  import csd_pkg::*;
(
  // Clock, reset and watched ports.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire csd_pkg::csd_req_t req_i,
  input wire csd_pkg::csd_resp_t resp_o,
  input wire csd_pkg::csd_pins_t pins_o
);
  // All checks share the one clock and its reset.
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  zero_wait_a: assert property (hreadyout_o && !hresp_o)
    else $error("slave stalled");
  one_select_a: assert property ($onehot0(~pins_o.cs_n))
    else $error("two selects low");
  done_idle_a: assert property (resp_o.done |-> pins_o.cs_n == 5'h1f)
    else $error("select low at done");
  strobe_sel_a: assert property (!pins_o.rd_n || !pins_o.wr_n |-> pins_o.cs_n != 5'h1f)
    else $error("strobe without select");
  ale_sel_a: assert property (pins_o.ale |-> pins_o.cs_n != 5'h1f && pins_o.rd_n && pins_o.wr_n)
    else $error("latch strobe misplaced");
  strobe_len_a: assert property ($fell(pins_o.rd_n) |-> (!pins_o.rd_n) [*8])
    else $error("read strobe short");
  take_req_a: assert property (req_i.valid && !resp_o.busy && !resp_o.done |=> resp_o.busy)
    else $error("request not taken");
  finish_a: assert property ($rose(resp_o.busy) |-> ##[1:1000] resp_o.done)
    else $error("cycle never ends");
  steer_sel_a: assert property (!pins_o.flash_sel_n || !pins_o.sram_sel_n |->
    !pins_o.cs_n[0] || !pins_o.cs_n[1])
    else $error("steered line without select");
  mux_addr_a: assert property (pins_o.ale && pins_o.doe |-> pins_o.dout == pins_o.addr[15:0])
    else $error("address missing on data lines");
  read_float_a: assert property (!pins_o.rd_n |-> !pins_o.doe)
    else $error("data driven during read");
  // Main decode outcomes.
  cover property (!pins_o.rd_n && !pins_o.cs_n[0]);
  cover property (!pins_o.rd_n && !pins_o.cs_n[1]);
  cover property (!pins_o.wr_n && !pins_o.cs_n[2]);
  cover property (pins_o.ale && pins_o.doe);
endmodule : csd_sva_chk
bind csd_decoder csd_sva_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .req_i(req_i), .resp_o(resp_o), .pins_o(pins_o));
`default_nettype wire

//--- csd_ext_mem.sv
// Purpose: Behavioural external memory answering read strobes.
// Assumes: No pull-ups on the data lines.
// Notes: Released lines toggle, so a stale value never passes for data.
`timescale 1ns/1ps
`default_nettype none
module csd_ext_mem
  import csd_pkg::*;
(
  // Clock, reset and bus pins.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire csd_pkg::csd_pins_t pins_i,
  // Data lines back to the decoder.
  output var logic [15:0] din_o
);
  // An address pattern while selected and read, otherwise the inverse of the last value.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      din_o <= 16'h0000;
    else if (!pins_i.rd_n && pins_i.cs_n != 5'h1f)
      din_o <= pins_i.addr[15:0] ^ 16'ha5c3;
    else
      din_o <= ~din_o;
  end
endmodule : csd_ext_mem
`default_nettype wire

//--- tb_chip_select_decoder.sv
// Purpose: Self-checking bench for the chip-select decoder.
// Assumes: 200 MHz clock, reset held six cycles.
// Notes: Registers come from a table; decode cases follow by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_chip_select_decoder;
  import csd_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready;
  csd_req_t req = '0;
  csd_resp_t resp;
  csd_pins_t pins;
  logic [15:0] din;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [4:0] seen;
  logic [1:0] steer;
  // Rows: offset, value written, value read back.
  logic [31:0] rows [7][3] = '{'{32'h04, 32'hffff04bd, 32'h04bd}, '{32'h08, 32'h060d, 32'h060d},
    '{32'h0c, 32'h04be, 32'h04be}, '{32'h14, 32'h1a42, 32'h1a42}, '{32'h18, 32'h200c, 32'h200c},
    '{32'h24, 32'hffff, 32'h0001}, '{32'h28, 32'h1234, 32'h0}};
  csd_decoder dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .req_i(req), .resp_o(resp), .din_i(din), .pins_o(pins));
  csd_ext_mem u_mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins_i(pins), .din_o(din));
  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Data the memory model returns for an address.
  function automatic logic [15:0] pat(input logic [23:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction : pat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  end
  endtask : chk
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
  begin
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
  end
  endtask : ahb
  // One word access; records which select went low.
  task automatic ext(input logic wr, input logic [23:0] a, input logic [15:0] d, input logic [4:0] cs,
    input logic [15:0] exp);
  begin
    seen = 5'h1f;
    steer = 2'b00;
    req <= '{1'b1, wr, 1'b1, a, d};
    @(posedge mclk_i);
    req.valid <= 1'b0;
    do
    begin
      @(posedge mclk_i);
      if (pins.cs_n !== 5'h1f)
        seen = pins.cs_n;
      if (pins.flash_sel_n === 1'b0)
        steer[0] = 1'b1;
      if (pins.sram_sel_n === 1'b0)
        steer[1] = 1'b1;
    end
    while (resp.done !== 1'b1);
    chk({27'h0, seen}, {27'h0, cs});
    if (!wr)
      chk({16'h0, resp.rdata}, {16'h0, exp});
  end
  endtask : ext
  task automatic wrap_up();
  begin
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : wrap_up
  // A hang ends the run well past the expected length.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      $display("MISMATCH %0t timeout", $time);
      wrap_up();
    end
  end
  // Table, then decode, swap and a second reset.
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i])
    begin
      ahb(1'b1, rows[i][0], rows[i][1]);
      ahb(1'b0, rows[i][0], 32'h0);
      chk(rd, rows[i][2]);
    end
    ext(1'b0, 24'h1a7ffe, 16'h0, 5'h1d, pat(24'h1a7ffe));
    chk({30'h0, steer}, 32'h2);
    ext(1'b0, 24'h1a8000, 16'h0, 5'h1e, pat(24'h1a8000));
    chk({30'h0, steer}, 32'h1);
    ext(1'b0, 24'h200000, 16'h0, 5'h1e, pat(24'h200000));
    ahb(1'b1, 32'h18, 32'h2000);
    ext(1'b0, 24'h200000, 16'h0, 5'h1b, (pat(24'h200001) << 8) | (pat(24'h200000) & 16'h00ff));
    ahb(1'b1, 32'h04, 32'h04fd);
    ext(1'b0, 24'h1a7ffe, 16'h0, 5'h1d, pat(24'h1a7ffe));
    ext(1'b1, 24'h200100, 16'h0303, 5'h1b, 16'h0);
    ahb(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h1);
    ext(1'b1, 24'h200000, 16'h0202, 5'h1b, 16'h0);
    ahb(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h2);
    ext(1'b0, 24'h1a8000, 16'h0, 5'h1e, pat(24'h1a8000));
    chk({30'h0, steer}, 32'h2);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h0480);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h0);
    ext(1'b0, 24'hfffffe, 16'h0, 5'h1e, pat(24'hfffffe));
    chk({30'h0, steer}, 32'h1);
    wrap_up();
  end
endmodule : tb_chip_select_decoder
`default_nettype wire
